/* File: ocq_regs.svh */
`ifndef OCQ_REGS_SVH
`define OCQ_REGS_SVH

// comparison window length in ns and its cycle count at 250 MHz
`define OCQ_WINDOW_NS 10000
`define OCQ_CLK_NS 4
`define OCQ_WINDOW_CYC (`OCQ_WINDOW_NS / `OCQ_CLK_NS)
// consecutive exceeding windows needed per delay setting
`define OCQ_RUN_SHORT 4'h1
`define OCQ_RUN_MID 4'h5
`define OCQ_RUN_LONG 4'ha
// sample width of sensed input and threshold
`define OCQ_SAMPLE_W 16
// accumulator width: sample plus log2 of window cycles
`define OCQ_ACC_W 28

`endif

/* File: ocq_pkg.sv */
package ocq_pkg;
    `include "ocq_regs.svh"

    typedef enum logic [1:0] {DLY_SHORT, DLY_MID, DLY_LONG} delay_sel_t;

    // sampled analogue front end values
    typedef struct packed {
        logic [`OCQ_SAMPLE_W-1:0] sense;
        logic [`OCQ_SAMPLE_W-1:0] limit;
    } sense_pair_t;

    // three-state delay strap: driven level and a float indication
    typedef struct packed {
        logic floating;
        logic level;
    } delay_strap_t;
endpackage

/* File: overcurrent_window_qualifier.sv */
`timescale 1ns/10ps
`include "ocq_regs.svh"
// Operation
// - a free 10 us window averages the input and compares at its end
// - shortest setting: one exceeding window pulls the alert low
// - a non-exceeding window leaves the alert unchanged; high means no overcurrent
// - middle setting: five consecutive exceeding windows pull the alert low
// - any non-exceeding window clears the run counter, no alert
// - longest setting: ten consecutive exceeding windows pull the alert low
// - delay strap: floating one window, low five, supply ten
// - window runs freely with no sync input or indicator
// - alert is active low open drain, driven low on overcurrent
module overcurrent_window_qualifier
    import ocq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // sampled sense input and programmed threshold
    input ocq_pkg::sense_pair_t sample_in,
    // delay selection strap
    input ocq_pkg::delay_strap_t delay_strap,
    // open-drain alert pin
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe
);
    import ocq_pkg::*;

    localparam int WIN_CYC = `OCQ_WINDOW_CYC;
    localparam logic [`OCQ_ACC_W-1:0] WIN_LAST = `OCQ_ACC_W'(WIN_CYC - 1);

    logic [`OCQ_ACC_W-1:0] win_cnt_q;
    logic [`OCQ_ACC_W-1:0] sense_acc_q;
    logic [`OCQ_ACC_W-1:0] limit_acc_q;
    logic [`OCQ_ACC_W-1:0] sense_sum_d;
    logic [`OCQ_ACC_W-1:0] limit_sum_d;
    logic win_end;
    logic exceed;
    logic [2:0] flt_q;
    logic [2:0] lvl_q;
    delay_sel_t dly_q;
    logic [3:0] need;
    logic [3:0] run_q;
    logic alert_low_q;

    ////////////////////////////////////////////////////////////////////////////
    // strap synchroniser, three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flt_q <= 3'h7;
            lvl_q <= 3'h0;
        end
        else
        begin
            flt_q <= {flt_q[1:0], delay_strap.floating};
            lvl_q <= {lvl_q[1:0], delay_strap.level};
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            dly_q <= DLY_SHORT;
        else if (flt_q[2] == flt_q[1] && lvl_q[2] == lvl_q[1])
        begin
            if (flt_q[2])
                dly_q <= DLY_SHORT;
            else if (lvl_q[2])
                dly_q <= DLY_LONG;
            else
                dly_q <= DLY_MID;
        end
    end

    // required run length per setting
    always_comb
    begin
        case (dly_q)
            DLY_SHORT: need = `OCQ_RUN_SHORT;
            DLY_MID: need = `OCQ_RUN_MID;
            DLY_LONG: need = `OCQ_RUN_LONG;
            default: need = `OCQ_RUN_SHORT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // free window timer
    assign win_end = (win_cnt_q == WIN_LAST);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            win_cnt_q <= '0;
        else if (win_end)
            win_cnt_q <= '0;
        else
            win_cnt_q <= win_cnt_q + `OCQ_ACC_W'(1);
    end

    // sums of 2500 full-scale samples still fit the accumulator width
    // window averaging; equal lengths so sums compare like averages
    assign sense_sum_d = sense_acc_q + `OCQ_ACC_W'(sample_in.sense);
    assign limit_sum_d = limit_acc_q + `OCQ_ACC_W'(sample_in.limit);
    assign exceed = (sense_sum_d > limit_sum_d);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sense_acc_q <= '0;
            limit_acc_q <= '0;
        end
        else if (win_end)
        begin
            sense_acc_q <= '0;
            limit_acc_q <= '0;
        end
        else
        begin
            sense_acc_q <= sense_sum_d;
            limit_acc_q <= limit_sum_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // consecutive run counter, cleared on non-exceeding window
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            run_q <= 4'h0;
        else if (win_end)
        begin
            if (!exceed)
                run_q <= 4'h0;
            else if (run_q < need)
                run_q <= run_q + 4'h1;
        end
    end

    // alert on reaching the run; otherwise unchanged
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            alert_low_q <= 1'b0;
        else if (win_end && exceed && (run_q + 4'h1 >= need))
            alert_low_q <= 1'b1;
    end

    // open-drain drive: output low, enable while asserting
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alert_out <= 1'b0;
            alert_oe <= 1'b0;
        end
        else
        begin
            alert_out <= 1'b0;
            alert_oe <= alert_low_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_window_period: assert property (win_end |=> !win_end [*8])
        else $error("window ended too soon");
    a_free_run: assert property (win_cnt_q != WIN_LAST |=> win_cnt_q == $past(win_cnt_q) + 1)
        else $error("window timer stalled");
    a_short_trip: assert property (win_end && exceed && dly_q == DLY_SHORT |=> alert_low_q)
        else $error("short setting did not trip");
    a_hold_quiet: assert property (!(win_end && exceed) |=> alert_low_q == $past(alert_low_q))
        else $error("alert changed without exceeding window");
    a_mid_run: assert property ($rose(alert_low_q) && dly_q == DLY_MID |-> $past(run_q) == 4'h4)
        else $error("mid setting tripped early");
    a_long_run: assert property ($rose(alert_low_q) && dly_q == DLY_LONG |-> $past(run_q) == 4'h9)
        else $error("long setting tripped early");
    a_run_clear: assert property (win_end && !exceed |=> run_q == 4'h0)
        else $error("run counter not cleared");
    a_pin_drive: assert property (alert_low_q |=> alert_oe && !alert_out)
        else $error("alert pin not driven low");
    a_reset_idle: assert property ($rose(resetn) |-> !alert_oe && run_q == 4'h0)
        else $error("alert not released at reset");

    ////////////////////////////////////////////////////////////////////////////
    // further window, alert and strap checks
    a_count_range: assert property (win_cnt_q <= WIN_LAST)
        else $error("window timer out of range");
    a_acc_clear: assert property (win_end |=> sense_acc_q == '0 && limit_acc_q == '0)
        else $error("window sums not cleared");
    a_trip_at_end: assert property ($rose(alert_low_q) |-> $past(win_end && exceed))
        else $error("alert tripped outside a window end");
    a_run_step: assert property (win_end && exceed && run_q < need |=>
        run_q == $past(run_q) + 4'h1)
        else $error("run counter did not advance");
    a_alert_sticky: assert property (alert_low_q |=> alert_low_q)
        else $error("latched alert dropped");
    a_oe_release: assert property (!alert_low_q |=> !alert_oe)
        else $error("alert pin driven without alert");
    a_strap_hold: assert property (flt_q[2] != flt_q[1] |=> dly_q == $past(dly_q))
        else $error("strap taken before stages agreed");

    // main scenario covers
    c_short_trip: cover property (dly_q == DLY_SHORT ##1 $rose(alert_low_q));
    c_mid_trip: cover property (dly_q == DLY_MID ##1 $rose(alert_low_q));
    c_long_trip: cover property (dly_q == DLY_LONG ##1 $rose(alert_low_q));
    c_run_break: cover property (run_q == 4'h3 && win_end && !exceed);
    c_pin_low: cover property (alert_oe && !alert_in);
endmodule

/* File: ocq_controller_model.sv */
`timescale 1ns/10ps
`include "ocq_regs.svh"
module ocq_controller_model
    import ocq_pkg::*;
#(
    parameter logic [15:0] TRIP_LEVEL = 16'h4000,
    parameter logic [15:0] NOISE_OFFSET_TERM = 16'h0020
)
(
    // device pins
    input wire logic alert_out,
    input wire logic alert_oe,
    input ocq_pkg::delay_strap_t delay_strap,
    // programmed threshold and resolved pin level
    output logic [`OCQ_SAMPLE_W-1:0] limit,
    output logic alert_pin
);
    ////////////////////////////////////////////////////////////////////////
    // noise offset choice
    // offset only added in the one-window setting
    assign limit = delay_strap.floating ? TRIP_LEVEL + NOISE_OFFSET_TERM : TRIP_LEVEL;
    ////////////////////////////////////////////////////////////////////////
    // open drain pin
    // pull-up holds the pin high unless the device drives it
    assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule

/* File: overcurrent_window_qualifier_test.sv */
`timescale 1ns/10ps
`include "ocq_regs.svh"
module overcurrent_window_qualifier_test;
    import ocq_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic hi = 1'b0;
    logic alert_out;
    logic alert_oe;
    logic alert_pin;
    delay_strap_t delay_strap = '{1'b1, 1'b0};
    logic [`OCQ_SAMPLE_W-1:0] limit;
    logic [`OCQ_SAMPLE_W-1:0] sense;
    int n_fail = 0;
    int n_checks = 0;
    // sense sits just above or below the threshold
    assign sense = hi ? limit + 16'h0008 : limit - 16'h0008;
    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial forever #2 core_clk = ~core_clk;
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
    overcurrent_window_qualifier i_dut (.core_clk(core_clk), .resetn(resetn),
        .sample_in({sense, limit}), .delay_strap(delay_strap), .alert_in(alert_pin),
        .alert_out(alert_out), .alert_oe(alert_oe));
    ocq_controller_model i_ctrl (.alert_out(alert_out), .alert_oe(alert_oe),
        .delay_strap(delay_strap), .limit(limit), .alert_pin(alert_pin));
    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic results();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rst(input logic fl, input logic lv);
        resetn <= 1'b0;
        delay_strap <= '{fl, lv};
        hi <= 1'b0;
        repeat (16) @(posedge core_clk);
        `CHK(alert_oe, 1'b0)
        resetn <= 1'b1;
    endtask
    // one window; exp is the alert state due from earlier windows
    task automatic win(input logic h, input logic exp);
        hi <= h;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(alert_oe, exp)
        `CHK(alert_pin, ~exp)
        `CHK(alert_out, 1'b0)
        repeat (2494) @(posedge core_clk);
        #1;
        `CHK(alert_oe, exp)
        repeat (3) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_short();
        rst(1'b1, 1'b0);
        win(1'b0, 1'b0);
        win(1'b1, 1'b0);
        win(1'b0, 1'b1);
        win(1'b0, 1'b1);
    endtask
    task automatic t_mid();
        rst(1'b0, 1'b0);
        repeat (4) win(1'b1, 1'b0);
        win(1'b0, 1'b0);
        repeat (5) win(1'b1, 1'b0);
        win(1'b0, 1'b1);
    endtask
    task automatic t_long();
        rst(1'b0, 1'b1);
        repeat (10) win(1'b1, 1'b0);
        win(1'b0, 1'b1);
    endtask
    initial
    begin
        @(posedge core_clk);
        t_short();
        t_mid();
        t_long();
        results();
    end
endmodule
